// file: dcs_pkg.sv
// Package for the decrement / invert / decrement-skip execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package dcs_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int RF_DEPTH = 128;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_INV = 6'h09;
  localparam logic [5:0] OPC_DSZ = 6'h0B;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  typedef enum logic {DCS_RUN, DCS_SQUASH} dcs_state_t;
endpackage : dcs_pkg

// file: dcs_regfile.sv
// Small data register file with registered read data, cleared by reset.
// Assumes a single clock; write and read in the same cycle return old data.
`timescale 1ns/1ps
module dcs_regfile #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Cleared so that no operand is ever unknown after reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mem[i] <= {DW{1'b0}};
      end else if (we && (waddr == AW'(i))) begin
        mem[i] <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= {DW{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : dcs_regfile

// file: dcs_exec.sv
// Execution of decrement, invert and decrement-skip-if-zero instructions.
// Assumes the fetch stage presents one instruction per clock with fetch_valid,
// and that operand read address is presented one cycle ahead (rd_addr, taken from fetch_insn).
`timescale 1ns/1ps
// Summary of operation
// - Decrement-skip opcode decrements addressed register, status flags untouched.
// - Destination bit 0 writes accumulator, 1 writes the register back.
// - Decrement-skip asserts skip exactly when decremented result is zero.
// - On skip, already prefetched next instruction is discarded.
// - Discarded instruction becomes idle cycle; two cycles when skipping.
module dcs_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic [13:0] fetch_insn,
  input wire logic fetch_valid,
  output logic [7:0] acc_out,
  output logic zero_flag,
  output logic skip,
  output logic [13:0] exec_insn,
  output logic exec_valid
);
  // Execute-stage registers
  logic [13:0] insn_q;
  logic valid_q;
  dcs_pkg::dcs_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d;
  logic z_q, z_d;

  // Bypass for a write that lands on the edge that also reads the next operand
  logic fwd_q;
  logic [7:0] fwd_data_q;
  logic [7:0] rf_rdata;

  // Decode of the word in execute, and operand address of the word in fetch
  wire [5:0] opcode = insn_q[dcs_pkg::OPC_HI:dcs_pkg::OPC_LO];
  wire dest = insn_q[dcs_pkg::DEST_BIT];
  wire [6:0] f_addr = insn_q[dcs_pkg::ADDR_W-1:0];
  wire [6:0] rd_addr = fetch_insn[dcs_pkg::ADDR_W-1:0];

  // A squashed slot never executes, whatever its valid bit says
  wire live = valid_q && (state_q == dcs_pkg::DCS_RUN);
  wire is_dec = live && (opcode == dcs_pkg::OPC_DEC);
  wire is_inv = live && (opcode == dcs_pkg::OPC_INV);
  wire is_dsz = live && (opcode == dcs_pkg::OPC_DSZ);
  wire any_op = is_dec || is_inv || is_dsz;

  // Operand: the bypassed value wins over stale read data
  wire [7:0] op_data = fwd_q ? fwd_data_q : rf_rdata;
  wire [7:0] dec_val = op_data - dcs_pkg::ONE;
  wire [7:0] inv_val = ~op_data;
  wire [7:0] result = is_inv ? inv_val : dec_val;
  wire res_zero = (result == dcs_pkg::ZERO);

  // Write-back select
  wire wr_en = any_op && (dest == dcs_pkg::DEST_REG);
  wire acc_en = any_op && (dest == dcs_pkg::DEST_ACC);
  wire zf_en = is_dec || is_inv;
  // Back-to-back ops on one register would otherwise read the old value
  wire fwd_hit = wr_en && (rd_addr == f_addr);

  assign skip = is_dsz && res_zero;

  // Operand read issued while the instruction sits in fetch
  dcs_regfile #(
    .DEPTH(dcs_pkg::RF_DEPTH),
    .AW(dcs_pkg::ADDR_W),
    .DW(dcs_pkg::DATA_W)
  ) u_dcs_regfile (
    .clk(clk),
    .reset(reset),
    .we(wr_en),
    .waddr(f_addr),
    .wdata(result),
    .raddr(rd_addr),
    .rdata(rf_rdata)
  );

  // Decrement-skip leaves the zero flag alone
  always_comb begin
    acc_d = acc_q;
    z_d = z_q;
    if (acc_en) begin
      acc_d = result;
    end
    if (zf_en) begin
      z_d = res_zero;
    end
  end

  // One idle slot after a skip, then back to normal issue
  always_comb begin
    state_d = dcs_pkg::DCS_RUN;
    case (state_q)
      dcs_pkg::DCS_RUN: begin
        if (skip) begin
          state_d = dcs_pkg::DCS_SQUASH;
        end
      end
      dcs_pkg::DCS_SQUASH: begin
        state_d = dcs_pkg::DCS_RUN;
      end
      default: begin
        state_d = dcs_pkg::DCS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      insn_q <= dcs_pkg::NOP_WORD;
      valid_q <= 1'b0;
    end else begin
      insn_q <= fetch_insn;
      valid_q <= fetch_valid;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= dcs_pkg::DCS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_q <= dcs_pkg::ACC_RESET;
      z_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      z_q <= z_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fwd_q <= 1'b0;
      fwd_data_q <= dcs_pkg::ZERO;
    end else begin
      fwd_q <= fwd_hit;
      fwd_data_q <= result;
    end
  end

  // Squashed slot shows as a NOP, not the discarded word
  assign exec_insn = (state_q == dcs_pkg::DCS_SQUASH) ? dcs_pkg::NOP_WORD : insn_q;
  assign exec_valid = live;
  assign acc_out = acc_q;
  assign zero_flag = z_q;

  AST_SKIP_SQUASH: assert property (@(posedge clk) disable iff (reset)
    skip |=> (state_q == dcs_pkg::DCS_SQUASH) && !exec_valid)
    else $error("skip did not squash next slot");
  AST_SQUASH_ONE: assert property (@(posedge clk) disable iff (reset)
    (state_q == dcs_pkg::DCS_SQUASH) |=> (state_q == dcs_pkg::DCS_RUN))
    else $error("squash lasted more than one cycle");
  AST_SKIP_ZERO: assert property (@(posedge clk) disable iff (reset)
    is_dsz |-> (skip == (dec_val == dcs_pkg::ZERO)))
    else $error("skip disagrees with zero result");
  AST_DSZ_FLAGS: assert property (@(posedge clk) disable iff (reset)
    (is_dsz && !is_dec && !is_inv) |=> $stable(zero_flag))
    else $error("decrement-skip changed zero flag");
  AST_DSZ_ACC: assert property (@(posedge clk) disable iff (reset)
    (is_dsz && dest == dcs_pkg::DEST_ACC) |=> acc_out == $past(dec_val))
    else $error("decrement-skip wrong accumulator value");
  AST_DEST_REG: assert property (@(posedge clk) disable iff (reset)
    (any_op && dest == dcs_pkg::DEST_REG) |=> $stable(acc_out))
    else $error("register destination touched accumulator");
  AST_DEST_ACC: assert property (@(posedge clk) disable iff (reset)
    (any_op && dest == dcs_pkg::DEST_ACC) |-> !wr_en)
    else $error("accumulator destination wrote register");
  AST_ZFLAG: assert property (@(posedge clk) disable iff (reset)
    (is_dec || is_inv) |=> zero_flag == ($past(result) == dcs_pkg::ZERO))
    else $error("zero flag wrong after decrement or invert");
  AST_NOSKIP_ONE: assert property (@(posedge clk) disable iff (reset)
    (is_dec || is_inv) |=> state_q == dcs_pkg::DCS_RUN)
    else $error("single-cycle op caused a stall");

  AST_DEC_ACC: assert property (@(posedge clk) disable iff (reset)
    (is_dec && dest == dcs_pkg::DEST_ACC) |=> acc_out == $past(op_data) - dcs_pkg::ONE)
    else $error("decrement wrong accumulator value");

  AST_INV_ACC: assert property (@(posedge clk) disable iff (reset)
    (is_inv && dest == dcs_pkg::DEST_ACC) |=> acc_out == ~$past(op_data))
    else $error("invert wrong accumulator value");

  AST_DSZ_WRITE: assert property (@(posedge clk) disable iff (reset)
    (is_dsz && dest == dcs_pkg::DEST_REG) |-> wr_en && (result == dec_val))
    else $error("decrement-skip did not write register");

  AST_SKIP_ONLY_DSZ: assert property (@(posedge clk) disable iff (reset)
    skip |-> is_dsz)
    else $error("skip raised by another instruction");

  AST_SQUASH_NOP: assert property (@(posedge clk) disable iff (reset)
    (state_q == dcs_pkg::DCS_SQUASH) |-> (exec_insn == dcs_pkg::NOP_WORD) && !exec_valid)
    else $error("squashed slot not shown as idle");

  AST_SQUASH_IDLE: assert property (@(posedge clk) disable iff (reset)
    (state_q == dcs_pkg::DCS_SQUASH) |-> !wr_en && !skip)
    else $error("squashed instruction had an effect");

  AST_SQUASH_HOLD: assert property (@(posedge clk) disable iff (reset)
    (state_q == dcs_pkg::DCS_SQUASH) |=> $stable(acc_out) && $stable(zero_flag))
    else $error("squashed instruction changed state");

  AST_NOSKIP_RUN: assert property (@(posedge clk) disable iff (reset)
    (is_dsz && !res_zero) |=> state_q == dcs_pkg::DCS_RUN)
    else $error("non-zero decrement-skip stalled");

  AST_FWD_VALUE: assert property (@(posedge clk) disable iff (reset)
    fwd_hit |=> op_data == $past(result))
    else $error("operand missed the preceding write");
endmodule : dcs_exec

// file: dcs_exec_tb_top.sv
// Testbench for dcs_exec: directed and random stream checked slot by slot.
// Assumes the register file clears on reset; a model array mirrors it.
`timescale 1ns/1ps
module dcs_exec_tb_top;
  logic clk = 0;
  logic reset = 1;
  logic fetch_valid = 0;
  logic [13:0] fetch_insn = 14'h0000;
  logic skip, zero_flag, exec_valid;
  logic [13:0] exec_insn;
  logic [7:0] acc_out;
  // Note layout: live, skip, zero flag, accumulator, word in execute
  logic [24:0] note_q[$];
  logic [24:0] note;
  logic [7:0] mem_m [128];
  logic [7:0] acc_m = 8'h00;
  logic z_m = 1'b0;
  logic squash_m = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  dcs_exec u_dcs_exec (.clk(clk), .reset(reset), .fetch_insn(fetch_insn),
    .fetch_valid(fetch_valid), .acc_out(acc_out), .zero_flag(zero_flag), .skip(skip),
    .exec_insn(exec_insn), .exec_valid(exec_valid));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      wrap_up();
    end
  end
  // Drives one slot and notes, in program order, what its execute cycle must show
  task automatic drive(input logic [13:0] insn, input logic v);
    logic live;
    logic sk;
    logic op;
    logic [7:0] r;
    logic [5:0] opc;
    opc = insn[13:8];
    live = v && !squash_m;
    op = live && (opc == dcs_pkg::OPC_DEC || opc == dcs_pkg::OPC_INV
      || opc == dcs_pkg::OPC_DSZ);
    r = (opc == dcs_pkg::OPC_INV) ? ~mem_m[insn[6:0]] : mem_m[insn[6:0]] - 8'h01;
    sk = op && (opc == dcs_pkg::OPC_DSZ) && (r == 8'h00);
    @(posedge clk);
    fetch_insn <= insn;
    fetch_valid <= v;
    note_q.push_back({live, sk, z_m, acc_m, squash_m ? 14'h0000 : insn});
    if (op) begin
      if (insn[7])
        mem_m[insn[6:0]] = r;
      else
        acc_m = r;
      if (opc != dcs_pkg::OPC_DSZ)
        z_m = (r == 8'h00);
    end
    squash_m = sk;
  endtask : drive
  // A note is due one cycle after driving
  always @(negedge clk) begin
    if (note_q.size() > 1) begin
      note = note_q.pop_front();
      check({15'h0000, exec_valid}, {15'h0000, note[24]});
      check({2'h0, exec_insn}, {2'h0, note[13:0]});
      check({15'h0000, skip}, {15'h0000, note[23]});
      check({8'h00, acc_out}, {8'h00, note[21:14]});
      check({15'h0000, zero_flag}, {15'h0000, note[22]});
    end
  end
  initial begin
    logic [5:0] opc;
    foreach (mem_m[i]) mem_m[i] = 8'h00;
    void'($urandom(81834));
    repeat (20) @(posedge clk);
    check({5'h00, acc_out, zero_flag, skip, exec_valid}, 16'h0000);
    check({2'h0, exec_insn}, 16'h0000);
    reset <= 0;
    // Decrement register 5 twice, invert it to one, skip on zero past the invert, then decrement to the accumulator
    drive({dcs_pkg::OPC_DEC, 1'b1, 7'h05}, 1'b1);
    drive({dcs_pkg::OPC_DEC, 1'b1, 7'h05}, 1'b1);
    drive({dcs_pkg::OPC_INV, 1'b1, 7'h05}, 1'b1);
    drive({dcs_pkg::OPC_DSZ, 1'b1, 7'h05}, 1'b1);
    drive({dcs_pkg::OPC_INV, 1'b0, 7'h05}, 1'b1);
    drive({dcs_pkg::OPC_DSZ, 1'b0, 7'h05}, 1'b1);
    repeat (400) begin
      case ($urandom_range(3))
        0: opc = dcs_pkg::OPC_DEC;
        1: opc = dcs_pkg::OPC_INV;
        2: opc = dcs_pkg::OPC_DSZ;
        default: opc = 6'($urandom_range(63));
      endcase
      // Few registers, so values revisit one and zero and skips happen
      drive({opc, 1'($urandom_range(1)), 7'($urandom_range(3))},
        1'($urandom_range(7) != 0));
    end
    repeat (3) drive(14'h0000, 1'b0);
    @(negedge clk);
    @(posedge clk);
    wrap_up();
  end
endmodule : dcs_exec_tb_top
